// >>> src/fpes_host.sv
// Host controller that writes, polls, protects and resets an asynchronous NOR flash
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module fpes_host
   import fpes_pkg::*;
#(
   parameter logic [31:0] ERASE_TYP_CYC   = CYC_ERASE_TYP,
   parameter logic [31:0] ERASE_TOUT_CYC  = CYC_ERASE_MAX,
   parameter logic [31:0] PROG_TOUT_CYC   = CYC_PROG_MAX
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire fpes_req_t         busReq,
   output      logic [31:0]       busRdata,
   output      logic              irq,
   output      fpes_pins_t        flashPins,
   input  wire logic [DATA_W-1:0] flashDqIn,
   input  wire logic              readyBusyN
);

   typedef enum logic [3:0] {
      S_IDLE, S_WR_LOW, S_WR_HIGH, S_POLL_WAIT, S_RD_LOW, S_RD_HIGH,
      S_RST_LOW, S_RST_WAIT, S_TEMP_SETUP, S_TEMP_WAITRDY, S_TEMP_HOLD
   } fpes_state_t;

   typedef struct packed {
      fpes_state_t       state;
      logic [3:0]        op;
      logic [1:0]        ctrl;
      logic [ADDR_W-1:0] addrReg;
      logic [DATA_W-1:0] dataReg;
      logic [DATA_W-1:0] rdReg;
      logic [DATA_W-1:0] prev;
      logic              first;
      logic [31:0]       timer;
      logic [31:0]       tout;
      logic              suspended;
      logic              tempActive;
      logic              timedOut;
      logic [IRQ_W-1:0]  irqStat;
      logic [IRQ_W-1:0]  irqEn;
      fpes_pins_t        pins;
      logic [31:0]       rdata;
      logic              irq;
   } fpes_regs_t;

   localparam fpes_regs_t REGS_RESET = '{state: S_IDLE, op: OP_WRITE, ctrl: '0,
                                         addrReg: '0, dataReg: '0, rdReg: '0, prev: '0,
                                         first: 1'b0, timer: '0, tout: '0,
                                         suspended: 1'b0, tempActive: 1'b0, timedOut: 1'b0,
                                         irqStat: '0, irqEn: '0, pins: PINS_IDLE,
                                         rdata: '0, irq: 1'b0};

   fpes_regs_t r;
   fpes_regs_t next_r;

   always_comb begin
      logic [IRQ_W-1:0]  setEv;
      logic [IRQ_W-1:0]  clrEv;
      logic              finish;
      logic              goOn;
      logic              polling;
      logic [ADDR_W-1:0] cmdAddr;
      logic [3:0]        cmdOp;
      setEv   = '0;
      cmdOp   = (r.state == S_IDLE) ? busReq.wdata[3:0] : r.op;
      clrEv   = '0;
      finish  = 1'b0;
      goOn    = 1'b0;
      polling = (r.op == OP_PROG_POLL) || (r.op == OP_ERASE_POLL);
      next_r  = r;
      next_r.rdata = '0;
      next_r.pins.programAccelerate = r.ctrl[CTRL_ACCEL];

      // Address presented on write cycles, with protect selector bits forced
      cmdAddr = r.addrReg;
      if (cmdOp == OP_PROTECT) begin
         cmdAddr[A_BIT6] = 1'b0;
         cmdAddr[A_BIT1] = 1'b1;
         cmdAddr[A_BIT0] = 1'b0;
      end else if (cmdOp == OP_UNPROTECT) begin
         cmdAddr[A_BIT6] = 1'b1;
         cmdAddr[A_BIT1] = 1'b1;
         cmdAddr[A_BIT0] = 1'b0;
      end

      if (r.timer != '0) begin
         next_r.timer = r.timer - 32'd1;
      end

      case (r.state)
         S_IDLE: begin
            // Commands only start once the previous operation has finished
            if (busReq.wr && busReq.addr == REG_CMD) begin
               next_r.op    = busReq.wdata[3:0];
               next_r.first = 1'b1;
               case (busReq.wdata[3:0])
                  OP_WRITE, OP_PROG_POLL, OP_ERASE_POLL, OP_PROTECT, OP_UNPROTECT: begin
                     next_r.state = S_WR_LOW;
                     next_r.timer = CYC_WP - 32'd1;
                  end
                  OP_READ, OP_SUSP_CHECK: begin
                     next_r.state = S_RD_HIGH;
                     next_r.timer = '0;
                  end
                  OP_TEMP_ENTER: begin
                     next_r.state              = S_TEMP_SETUP;
                     next_r.pins.resetElevated = 1'b1;
                     next_r.timer              = CYC_RSP - 32'd1;
                  end
                  OP_TEMP_EXIT: begin
                     next_r.state = S_TEMP_WAITRDY;
                  end
                  OP_HW_RESET: begin
                     next_r.state       = S_RST_LOW;
                     next_r.pins.resetN = 1'b0;
                     next_r.timer       = CYC_RP - 32'd1;
                  end
                  default: begin
                     setEv[IRQ_DONE] = 1'b1;
                  end
               endcase
               if (busReq.wdata[3:0] == OP_WRITE || busReq.wdata[3:0] == OP_PROG_POLL ||
                   busReq.wdata[3:0] == OP_ERASE_POLL || busReq.wdata[3:0] == OP_PROTECT ||
                   busReq.wdata[3:0] == OP_UNPROTECT) begin
                  next_r.pins.ceN   = 1'b0;
                  next_r.pins.weN   = 1'b0;
                  next_r.pins.dqOe  = 1'b1;
                  next_r.pins.dqOut = r.dataReg;
                  // Address goes out with the write strobe so the flash latches it
                  next_r.pins.addr  = cmdAddr;
               end
            end
         end
         S_WR_LOW: begin
            next_r.pins.addr = cmdAddr;
            if (r.timer == '0) begin
               next_r.pins.weN  = 1'b1;
               next_r.pins.ceN  = 1'b1;
               next_r.state     = S_WR_HIGH;
               next_r.timer     = CYC_WPH - 32'd1;
            end
         end
         S_WR_HIGH: begin
            next_r.pins.dqOe = 1'b0;
            if (r.timer == '0) begin
               if (r.op == OP_PROG_POLL) begin
                  next_r.state = S_POLL_WAIT;
                  next_r.tout  = PROG_TOUT_CYC;
                  // First status read waits out busy onset, or the accelerated program time when acceleration is on
                  next_r.timer = r.ctrl[CTRL_ACCEL] ? CYC_ACCPROG - 32'd1
                                                    : CYC_BUSY - 32'd1;
               end else if (r.op == OP_ERASE_POLL) begin
                  next_r.state = S_POLL_WAIT;
                  next_r.tout  = ERASE_TOUT_CYC;
                  next_r.timer = (ERASE_TYP_CYC > CYC_BUSY) ? ERASE_TYP_CYC - 32'd1
                                                            : CYC_BUSY - 32'd1;
               end else begin
                  finish = 1'b1;
               end
            end
         end
         S_POLL_WAIT: begin
            if (r.timer == '0) begin
               next_r.state = S_RD_HIGH;
            end
         end
         S_RD_HIGH: begin
            next_r.pins.addr = r.addrReg;
            if (r.timer == '0) begin
               next_r.pins.oeN = 1'b0;
               next_r.pins.ceN = 1'b0;
               next_r.state    = S_RD_LOW;
               next_r.timer    = CYC_ACC - 32'd1;
            end
         end
         S_RD_LOW: begin
            if (r.timer == '0) begin
               next_r.rdReg = flashDqIn;
               next_r.prev  = flashDqIn;
               next_r.first = 1'b0;
               case (r.op)
                  OP_PROG_POLL: begin
                     goOn = flashDqIn[BIT_POLL] != r.dataReg[BIT_POLL];
                  end
                  OP_ERASE_POLL: begin
                     goOn = r.first || (flashDqIn[BIT_TOGGLE] != r.prev[BIT_TOGGLE]);
                  end
                  OP_SUSP_CHECK: begin
                     goOn = r.first;
                     if (!r.first) begin
                        next_r.suspended = flashDqIn[BIT_SUSP] != r.prev[BIT_SUSP];
                        setEv[IRQ_SUSP]  = flashDqIn[BIT_SUSP] != r.prev[BIT_SUSP];
                     end
                  end
                  default: begin
                     goOn = 1'b0;
                  end
               endcase
               next_r.pins.oeN = 1'b1;
               // Chip enable framing releases chip enable between status reads
               next_r.pins.ceN = !goOn || r.ctrl[CTRL_CE_FRAME];
               if (goOn) begin
                  next_r.state = S_RD_HIGH;
                  next_r.timer = CYC_OEPH - 32'd1;
               end else begin
                  finish = 1'b1;
               end
            end
         end
         S_RST_LOW: begin
            if (r.timer == '0) begin
               next_r.pins.resetN        = 1'b1;
               next_r.pins.resetElevated = 1'b0;
               next_r.tempActive         = 1'b0;
               next_r.state              = S_RST_WAIT;
               next_r.timer              = CYC_READY - 32'd1;
            end
         end
         S_RST_WAIT: begin
            if (r.timer == '0) begin
               finish = 1'b1;
            end
         end
         S_TEMP_SETUP: begin
            if (r.timer == '0) begin
               next_r.tempActive = 1'b1;
               finish            = 1'b1;
            end
         end
         S_TEMP_WAITRDY: begin
            if (readyBusyN) begin
               next_r.state = S_TEMP_HOLD;
               next_r.timer = CYC_RRB - 32'd1;
            end
         end
         S_TEMP_HOLD: begin
            if (r.timer == '0) begin
               next_r.pins.resetElevated = 1'b0;
               next_r.tempActive         = 1'b0;
               finish                    = 1'b1;
            end
         end
         default: begin
            next_r.state = S_IDLE;
            next_r.pins  = PINS_IDLE;
         end
      endcase

      // Polling gives up after the worst-case operation time
      if (polling && (r.state == S_POLL_WAIT || r.state == S_RD_LOW ||
                      r.state == S_RD_HIGH) && !finish) begin
         // A read pulse in progress runs to its full length before the abort
         if (r.tout == '0 && !(r.state == S_RD_LOW && r.timer != '0)) begin
            next_r.timedOut   = 1'b1;
            setEv[IRQ_TIMEOUT] = 1'b1;
            next_r.pins.ceN    = 1'b1;
            next_r.pins.oeN    = 1'b1;
            finish             = 1'b1;
         end else if (r.tout != '0) begin
            next_r.tout = r.tout - 32'd1;
         end
      end

      if (finish) begin
         next_r.state    = S_IDLE;
         setEv[IRQ_DONE] = 1'b1;
      end
      if (r.state == S_IDLE && busReq.wr && busReq.addr == REG_CMD) begin
         next_r.timedOut = 1'b0;
      end

      // Software register writes
      if (busReq.wr) begin
         case (busReq.addr)
            REG_CTRL:   next_r.ctrl    = busReq.wdata[1:0];
            REG_ADDR:   if (r.state == S_IDLE) next_r.addrReg = busReq.wdata[ADDR_W-1:0];
            REG_DATA:   if (r.state == S_IDLE) next_r.dataReg = busReq.wdata[DATA_W-1:0];
            REG_IRQCLR: clrEv          = busReq.wdata[IRQ_W-1:0];
            REG_IRQEN:  next_r.irqEn   = busReq.wdata[IRQ_W-1:0];
            default:    next_r.irqEn   = next_r.irqEn;
         endcase
      end
      if (busReq.rd) begin
         case (busReq.addr)
            REG_CTRL:    next_r.rdata = {30'h0, r.ctrl};
            REG_ADDR:    next_r.rdata = {{(32-ADDR_W){1'b0}}, r.addrReg};
            REG_DATA:    next_r.rdata = {{(32-DATA_W){1'b0}}, r.dataReg};
            REG_STATUS:  next_r.rdata = {27'h0, r.timedOut, r.suspended, r.tempActive,
                                         readyBusyN, r.state != S_IDLE};
            REG_RDDATA:  next_r.rdata = {{(32-DATA_W){1'b0}}, r.rdReg};
            REG_IRQSTAT: next_r.rdata = {29'h0, r.irqStat};
            REG_IRQEN:   next_r.rdata = {29'h0, r.irqEn};
            default:     next_r.rdata = 32'h0;
         endcase
      end

      // A new event wins over a clear in the same cycle
      next_r.irqStat = (r.irqStat & ~clrEv) | setEv;
      next_r.irq     = |(next_r.irqStat & next_r.irqEn);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign busRdata  = r.rdata;
   assign irq       = r.irq;
   assign flashPins = r.pins;

endmodule : fpes_host

// >>> src/fpes_pkg.sv
// Constants and types for the flash program/erase status host controller
package fpes_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int REG_AW = 8;
   localparam int CLK_NS = 50;

   // Pin timing figures in nanoseconds
   localparam int T_WP_NS    = 35;
   localparam int T_WPH_NS   = 30;
   localparam int T_ACC_NS   = 85;
   localparam int T_OEPH_NS  = 20;
   localparam int T_BUSY_NS  = 90;
   localparam int T_RSP_NS   = 4000;
   localparam int T_RRB_NS   = 4000;
   localparam int T_RP_NS    = 500;
   localparam int T_READY_NS = 20000;
   localparam int T_ACCPROG_NS = 4000;
   // Operation durations in larger units
   localparam int PROG_MAX_US  = 210;
   localparam int ERASE_TYP_MS = 700;
   localparam int ERASE_MAX_MS = 15000;

   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : ceil_cyc

   localparam logic [31:0] CYC_WP      = 32'(ceil_cyc(T_WP_NS));
   localparam logic [31:0] CYC_WPH     = 32'(ceil_cyc(T_WPH_NS));
   localparam logic [31:0] CYC_ACC     = 32'(ceil_cyc(T_ACC_NS));
   localparam logic [31:0] CYC_OEPH    = 32'(ceil_cyc(T_OEPH_NS));
   localparam logic [31:0] CYC_BUSY    = 32'(ceil_cyc(T_BUSY_NS));
   localparam logic [31:0] CYC_RSP     = 32'(ceil_cyc(T_RSP_NS));
   localparam logic [31:0] CYC_RRB     = 32'(ceil_cyc(T_RRB_NS));
   localparam logic [31:0] CYC_RP      = 32'(ceil_cyc(T_RP_NS));
   localparam logic [31:0] CYC_READY   = 32'(ceil_cyc(T_READY_NS));
   localparam logic [31:0] CYC_ACCPROG = 32'(ceil_cyc(T_ACCPROG_NS));
   localparam logic [31:0] CYC_PROG_MAX  = 32'(PROG_MAX_US * (1000 / CLK_NS));
   localparam logic [31:0] CYC_ERASE_TYP = 32'(ERASE_TYP_MS * (1000000 / CLK_NS));
   localparam logic [31:0] CYC_ERASE_MAX = 32'(ERASE_MAX_MS * (1000000 / CLK_NS));

   // Register byte offsets
   localparam logic [REG_AW-1:0] REG_CTRL    = 8'h00;
   localparam logic [REG_AW-1:0] REG_ADDR    = 8'h04;
   localparam logic [REG_AW-1:0] REG_DATA    = 8'h08;
   localparam logic [REG_AW-1:0] REG_CMD     = 8'h0C;
   localparam logic [REG_AW-1:0] REG_STATUS  = 8'h10;
   localparam logic [REG_AW-1:0] REG_RDDATA  = 8'h14;
   localparam logic [REG_AW-1:0] REG_IRQSTAT = 8'h18;
   localparam logic [REG_AW-1:0] REG_IRQCLR  = 8'h1C;
   localparam logic [REG_AW-1:0] REG_IRQEN   = 8'h20;

   // Operation codes written to the command register
   localparam logic [3:0] OP_WRITE      = 4'h0;
   localparam logic [3:0] OP_READ       = 4'h1;
   localparam logic [3:0] OP_PROG_POLL  = 4'h2;
   localparam logic [3:0] OP_ERASE_POLL = 4'h3;
   localparam logic [3:0] OP_SUSP_CHECK = 4'h4;
   localparam logic [3:0] OP_PROTECT    = 4'h5;
   localparam logic [3:0] OP_UNPROTECT  = 4'h6;
   localparam logic [3:0] OP_TEMP_ENTER = 4'h7;
   localparam logic [3:0] OP_TEMP_EXIT  = 4'h8;
   localparam logic [3:0] OP_HW_RESET   = 4'h9;

   // Field positions
   localparam int CTRL_CE_FRAME = 0;
   localparam int CTRL_ACCEL    = 1;
   localparam int IRQ_W         = 3;
   localparam int IRQ_DONE      = 0;
   localparam int IRQ_TIMEOUT   = 1;
   localparam int IRQ_SUSP      = 2;
   localparam int BIT_POLL      = 7;
   localparam int BIT_TOGGLE    = 6;
   localparam int BIT_SUSP      = 2;
   localparam int A_BIT6        = 6;
   localparam int A_BIT1        = 1;
   localparam int A_BIT0        = 0;

   typedef struct packed {
      logic              ceN;
      logic              oeN;
      logic              weN;
      logic              resetN;
      logic              resetElevated;
      logic              programAccelerate;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dqOut;
      logic              dqOe;
   } fpes_pins_t;

   typedef struct packed {
      logic [REG_AW-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } fpes_req_t;

   localparam fpes_pins_t PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1,
                                        resetElevated: 1'b0, programAccelerate: 1'b0,
                                        addr: '0, dqOut: '0, dqOe: 1'b0};
endpackage : fpes_pkg

// >>> test/fpes_host_props.sv
// Port-level checks for the flash host controller
module fpes_host_props
   import fpes_pkg::*;
#(
   parameter logic [31:0] ERASE_TYP_CYC  = CYC_ERASE_TYP,
   parameter logic [31:0] ERASE_TOUT_CYC = CYC_ERASE_MAX,
   parameter logic [31:0] PROG_TOUT_CYC  = CYC_PROG_MAX
) (
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire fpes_req_t         busReq,
   input wire logic [31:0]       busRdata,
   input wire logic              irq,
   input wire fpes_pins_t        flashPins,
   input wire logic [DATA_W-1:0] flashDqIn,
   input wire logic              readyBusyN
);
   fpes_pins_t  fp;
   logic [31:0] elevCnt;
   logic [31:0] rdyCnt;
   logic        cmdW;
   assign fp   = flashPins;
   assign cmdW = busReq.wr && busReq.addr == REG_CMD && fp.weN && fp.oeN;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Cycles spent at elevated reset, and since ready last rose
   always_ff @(posedge sys_clk) begin
      elevCnt <= (reset || !fp.resetElevated) ? 32'h0 : elevCnt + 32'h1;
      rdyCnt  <= (reset || !readyBusyN) ? 32'h0 : rdyCnt + 32'h1;
   end
   property p_idle; disable iff (1'b0) reset |=> fp.ceN && fp.weN && fp.resetN && !irq; endproperty
   a_idle: assert property (p_idle) else $error("pins not idle after reset");
   property p_prot; cmdW && busReq.wdata[3:0] == OP_PROTECT |-> ##[1:4]
      (fp.dqOe && !fp.addr[A_BIT6] && fp.addr[A_BIT1] && !fp.addr[A_BIT0]); endproperty
   a_prot: assert property (p_prot) else $error("protect address bits wrong");
   property p_unprot; cmdW && busReq.wdata[3:0] == OP_UNPROTECT |-> ##[1:4]
      (fp.dqOe && fp.addr[A_BIT6] && fp.addr[A_BIT1] && !fp.addr[A_BIT0]); endproperty
   a_unprot: assert property (p_unprot) else $error("unprotect address bits wrong");
   property p_setup; !fp.weN && fp.resetElevated |-> elevCnt >= CYC_RSP; endproperty
   a_setup: assert property (p_setup) else $error("write before elevated setup");
   property p_hold; $fell(fp.resetElevated) |-> rdyCnt >= CYC_RRB; endproperty
   a_hold: assert property (p_hold) else $error("elevated reset left too early");
   property p_rdlen; $fell(fp.oeN) |=> !fp.oeN ##[1:2] fp.oeN; endproperty
   a_rdlen: assert property (p_rdlen) else $error("read pulse length wrong");
   property p_nowr; !readyBusyN |-> fp.weN; endproperty
   a_nowr: assert property (p_nowr) else $error("write while flash busy");
   property p_rstpw;
      $fell(fp.resetN) |-> !fp.resetN [*8] ##1 !fp.resetN ##1 !fp.resetN;
   endproperty
   a_rstpw: assert property (p_rstpw) else $error("flash reset pulse too short");
   property p_rdz; !busReq.rd |=> busRdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside read slot");
   c_prog: cover property (cmdW && busReq.wdata[3:0] == OP_PROG_POLL);
   c_irq: cover property ($rose(irq));
   c_exit: cover property ($fell(fp.resetElevated));
endmodule : fpes_host_props

bind fpes_host fpes_host_props #(.ERASE_TYP_CYC(ERASE_TYP_CYC), .ERASE_TOUT_CYC(ERASE_TOUT_CYC),
   .PROG_TOUT_CYC(PROG_TOUT_CYC)) fpes_host_props_inst (.sys_clk(sys_clk), .reset(reset),
   .busReq(busReq), .busRdata(busRdata), .irq(irq), .flashPins(flashPins),
   .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));

// >>> test/fpes_flash_model.sv
// Behavioural flash array answering the host controller pins
module fpes_flash_model
   import fpes_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire fpes_pins_t        flashPins,
   input  wire logic [15:0]       busyCyc,
   input  wire logic              suspOn,
   output      logic [DATA_W-1:0] flashDqIn,
   output      logic              readyBusyN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] arr = 16'hFFFF;
   logic [ADDR_W-1:0] lastAddr = '0;
   logic [15:0]       cnt = 16'h0;
   logic              wasWr = 1'b0;
   logic              wasRd = 1'b0;
   logic              tog = 1'b0;
   wire               rdSel = !flashPins.ceN && !flashPins.oeN;
   wire               inSusp = suspOn && flashPins.addr[19:12] == 8'h5A;
   // Both enables becoming low together after either was high starts a fresh status read
   wire               t = (rdSel && !wasRd) ? !tog : tog;
   wire               busy = cnt != 16'h0;
   initial begin
      flashDqIn = 16'h0;
      readyBusyN = 1'b1;
   end
   always @(posedge sys_clk) begin
      wasWr <= !flashPins.weN && !flashPins.ceN;
      wasRd <= rdSel;
      if (!flashPins.resetN) begin
         cnt <= 16'h0;
         readyBusyN <= 1'b1;
      end else if (wasWr && flashPins.weN) begin
         arr <= flashPins.dqOut;
         lastAddr <= flashPins.addr;
         cnt <= busyCyc;
         readyBusyN <= busyCyc == 16'h0;
      end else if (cnt != 16'h0) begin
         cnt <= cnt - 16'h1;
         readyBusyN <= cnt == 16'h1;
      end
      tog <= t;
      if (rdSel) begin
         flashDqIn <= {arr[15:8], busy ? ~arr[7] : arr[7], busy ? t : arr[6], arr[5:3],
                       inSusp ? t : arr[2], arr[1:0]};
      end else begin
         flashDqIn <= ~flashDqIn;
      end
   end
endmodule : fpes_flash_model

// >>> test/fpes_host_tb.sv
// Self-checking bench for the flash host controller
module fpes_host_tb
   import fpes_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              sys_clk = 1'b0;
   logic              reset = 1'b1;
   fpes_req_t         busReq = '0;
   logic [31:0]       busRdata;
   logic              irq;
   logic              readyBusyN;
   logic              suspOn = 1'b0;
   logic              rdTaken = 1'b0;
   fpes_pins_t        flashPins;
   logic [DATA_W-1:0] flashDqIn;
   logic [15:0]       busyCyc = 16'h0;
   logic [31:0]       expQ[$];
   logic [31:0]       mskQ[$];
   logic [31:0]       m;
   logic [31:0]       a;
   logic [31:0]       d;
   int                errorCnt = 0;
   int                numChecks = 0;
   always #25 sys_clk = ~sys_clk;
   fpes_host #(.ERASE_TYP_CYC(32'hA), .ERASE_TOUT_CYC(32'hC8), .PROG_TOUT_CYC(32'h96))
      fpes_host_inst (.sys_clk(sys_clk), .reset(reset), .busReq(busReq), .busRdata(busRdata),
      .irq(irq), .flashPins(flashPins), .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));
   fpes_flash_model fpes_flash_model_inst (.sys_clk(sys_clk), .flashPins(flashPins),
      .busyCyc(busyCyc), .suspOn(suspOn), .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d errors %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Reads queue their expectation; writes ignore the mask
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] v, m);
      if (!w) begin
         expQ.push_back(v);
         mskQ.push_back(m);
      end
      @(posedge sys_clk);
      busReq <= '{addr: ad, wdata: v, wr: w, rd: !w};
      @(posedge sys_clk);
      busReq <= '{addr: ad, wdata: v, wr: 1'b0, rd: 1'b0};
   endtask : bus
   task automatic runOp(input logic [3:0] op, input logic [15:0] bc, input logic [31:0] st);
      int i;
      busyCyc <= bc;
      bus(1'b1, REG_CMD, {28'h0, op}, 32'h0);
      for (i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge sys_clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      bus(1'b0, REG_IRQSTAT, st, 32'h7);
      bus(1'b1, REG_IRQCLR, 32'h7, 32'h0);
      bus(1'b0, REG_IRQSTAT, 32'h0, 32'h7);
   endtask : runOp
   always @(posedge sys_clk) rdTaken <= busReq.rd;
   always @(negedge sys_clk) begin
      if (rdTaken) begin
         m = mskQ.pop_front();
         check("read data", busRdata & m, expQ.pop_front() & m);
      end
   end
   initial begin
      #(CLK_NS * 40000);
      errorCnt++;
      summarize();
   end
   initial begin
      void'($urandom(84882));
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      bus(1'b0, REG_CTRL, 32'h0, 32'hFFFFFFFF);
      bus(1'b0, REG_STATUS, 32'h2, 32'h1F);
      bus(1'b0, 8'h3C, 32'h0, 32'hFFFFFFFF);
      bus(1'b1, REG_IRQEN, 32'h7, 32'h0);
      bus(1'b0, REG_IRQEN, 32'h7, 32'h7);
      for (int k = 0; k < 3; k++) begin
         a = $urandom() & 32'hFFFFF;
         d = $urandom() & 32'hFFFF;
         bus(1'b1, REG_CTRL, {30'h0, k[1], 1'b0}, 32'h0);
         bus(1'b1, REG_ADDR, a, 32'h0);
         bus(1'b0, REG_ADDR, a, 32'hFFFFF);
         check("accel pin", {31'h0, flashPins.programAccelerate}, {31'h0, k[1]});
         bus(1'b1, REG_DATA, d, 32'h0);
         runOp(OP_PROG_POLL, k[1] ? 16'h50 : (16'($urandom()) & 16'h1F) | 16'h2,
               32'h1);
         bus(1'b0, REG_RDDATA, d, 32'hFFFF);
         bus(1'b0, REG_STATUS, 32'h2, 32'h13);
      end
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, REG_CTRL, {31'h0, k[0]}, 32'h0);
         bus(1'b1, REG_ADDR, $urandom() & 32'hFFFFF, 32'h0);
         runOp(OP_ERASE_POLL, 16'h28, 32'h1);
      end
      suspOn <= 1'b1;
      bus(1'b1, REG_ADDR, 32'h5A123, 32'h0);
      runOp(OP_SUSP_CHECK, 16'h0, 32'h5);
      bus(1'b1, REG_ADDR, 32'h12345, 32'h0);
      runOp(OP_SUSP_CHECK, 16'h0, 32'h1);
      suspOn <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, REG_ADDR, ($urandom() & 32'hFFFBC) | (k ? 32'h1 : 32'h41), 32'h0);
         runOp(k ? OP_UNPROTECT : OP_PROTECT, 16'h0, 32'h1);
         check("sector bits", 32'(fpes_flash_model_inst.lastAddr & 20'h43),
               k ? 32'h42 : 32'h2);
      end
      runOp(OP_READ, 16'h0, 32'h1);
      bus(1'b0, REG_RDDATA, d, 32'hFFFF);
      runOp(4'hF, 16'h0, 32'h1);
      runOp(OP_TEMP_ENTER, 16'h0, 32'h1);
      bus(1'b0, REG_STATUS, 32'h4, 32'h4);
      bus(1'b1, REG_IRQEN, 32'h0, 32'h0);
      bus(1'b1, REG_CMD, {28'h0, OP_WRITE}, 32'h0);
      repeat (10) @(negedge sys_clk);
      check("masked irq", {31'h0, irq}, 32'h0);
      bus(1'b0, REG_IRQSTAT, 32'h1, 32'h7);
      bus(1'b1, REG_IRQEN, 32'h7, 32'h0);
      repeat (3) @(negedge sys_clk);
      check("unmasked irq", {31'h0, irq}, 32'h1);
      bus(1'b1, REG_IRQCLR, 32'h7, 32'h0);
      runOp(OP_TEMP_EXIT, 16'h0, 32'h1);
      bus(1'b0, REG_STATUS, 32'h0, 32'h4);
      bus(1'b1, REG_CTRL, 32'h0, 32'h0);
      runOp(OP_PROG_POLL, 16'h1F4, 32'h3);
      bus(1'b0, REG_STATUS, 32'h10, 32'h12);
      runOp(OP_HW_RESET, 16'h0, 32'h1);
      check("ready after abort", {31'h0, readyBusyN}, 32'h1);
      repeat (3) @(posedge sys_clk);
      summarize();
   end
endmodule : fpes_host_tb
